// ---- rtl/dtx_header_modulator.sv ----
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RL1) Preamble length in symbols equals the preamble-length register.
// (RL2) Preamble and header DBPSK, then payload switches to chosen modulation.
// (RL3) Payload modulation comes from setup register bits one and zero.
// (RL4) Signal field takes the signal register matching the chosen modulation.
// (RL5) Service field carries the service register value.
// (RL6) Length field carries the two length registers.
// (RL7) Payload bits sent unaltered in order, then dummy bits appended.
// (RL8) Controller drops transmit power enable at packet end.
// (RL9) Whole packet passes a 7-bit self-synchronizing scrambler with taps.
// (RL10) All tap bits zero passes data unscrambled.
// (RL11) Output is input XOR tapped sum; register shifts in output.
// (RL12) Scrambler is seeded with 6C before each packet.
// (RL13) Header and 1 Mbps data differentially encoded, same on I and Q.
// (RL14) 2 Mbps dibits, first bit D0, rotate 0, +90, +180, -90.
// (RL15) Rotation counterclockwise; control bits reverse transmit or receive.
// (RL16) Keying modes take 4-bit nibbles, one or two per symbol.
// (RL17) Dibit bits split to I and Q; low rates spread by Barker.
// (RL18) Nibble holds sign and magnitude; magnitude picks code, sign inverts.
// (RL19) Walsh codes are 03, 0C, 30, 3F, 56, 59, 65, 6A.
// (RL20) Walsh chips leave at chip rate, eight chips per symbol.
// (RL21) Last header encoder output is XORed onto every high-rate chip.
// (RL22) At 11 Mbps first code drives Q, second drives I.
// (RL23) Preamble bits are all ones before scrambling.
// (RL24) Header is SFD 16, signal 8, service 8, length 16, CRC 16.
// (RL25) CRC preset ones, x16+x12+x5+1, complemented, sent MSB first.
module dtx_header_modulator
  import dtx_pkg::*;
(
  // Clock and reset
  input  wire  logic           clk_i,
  input  wire  logic           rst_i,
  // Register bus
  input  wire  dtx_wb_req_type wb_req_i,
  output var   dtx_wb_rsp_type wb_rsp_o,
  // Controller
  input  wire  logic           transmit_power_enable_i,
  input  wire  dtx_bit_type    tx_bit_i,
  output logic                 tx_bit_ready_o,
  // Baseband chips
  output var   dtx_chip_type   chip_o,
  output logic                 tx_active_o
);

  typedef struct packed {
    dtx_st_type      st;
    dtx_ph_type      ph;
    logic [7:0]      cnt;
    logic [15:0]     crc;
    logic [6:0]      scr;
    logic [7:0]      fbits;
    logic [3:0]      fcnt;
    logic [3:0]      fk;
    logic            fdata;
    logic [3:0]      chip;
    logic            cur_mbok;
    logic            cur_i;
    logic            cur_q;
    logic [7:0]      code_i;
    logic [7:0]      code_q;
    logic [1:0]      quad;
    logic            phref;
    logic            out_en;
    logic            last;
    logic [3:0]      dcnt;
    logic            pe_s1;
    logic            pe_s2;
    logic            pe_d;
    logic            ready;
    logic            ci;
    logic            cq;
    logic            active;
    logic            ack;
    logic [7:0]      rdat;
    logic            underrun;
    logic [7:0]      pre_len;
    logic [7:0]      sfd_to;
    logic [3:0][7:0] sig;
    logic [7:0]      setup;
    logic [7:0]      srv;
    logic [7:0]      len_hi;
    logic [7:0]      len_lo;
    logic [7:0]      taps;
    logic [7:0]      rot;
  } dtx_state_type;

  dtx_state_type s_ff;
  dtx_state_type nxt_s;

  function automatic logic [7:0] walsh(input logic [2:0] nibble_magnitude);
    case (nibble_magnitude) // [RL19]
      3'h0:    walsh = 8'h03;
      3'h1:    walsh = 8'h0C;
      3'h2:    walsh = 8'h30;
      3'h3:    walsh = 8'h3F;
      3'h4:    walsh = 8'h56;
      3'h5:    walsh = 8'h59;
      3'h6:    walsh = 8'h65;
      default: walsh = 8'h6A;
    endcase
  endfunction : walsh

  function automatic logic [3:0] bits_per_sym(input logic [1:0] m);
    case (m) // [RL16]
      MOD_DBPSK: bits_per_sym = 4'h1;
      MOD_DQPSK: bits_per_sym = 4'h2;
      MOD_BOK:   bits_per_sym = 4'h4;
      default:   bits_per_sym = 4'h8;
    endcase
  endfunction : bits_per_sym

  function automatic logic [7:0] ph_last(input dtx_ph_type p,
                                         input logic [7:0] pl);
    case (p)
      PH_PRE:  ph_last = 8'(pl - 8'h01); // [RL1]
      PH_SIG:  ph_last = BYTE_LAST;
      PH_SRV:  ph_last = BYTE_LAST;
      default: ph_last = WORD_LAST;
    endcase
  endfunction : ph_last

  function automatic dtx_ph_type ph_next(input dtx_ph_type p);
    case (p) // [RL24]
      PH_PRE:  ph_next = PH_SFD;
      PH_SFD:  ph_next = PH_SIG;
      PH_SIG:  ph_next = PH_SRV;
      PH_SRV:  ph_next = PH_LEN;
      PH_LEN:  ph_next = PH_CRC;
      PH_CRC:  ph_next = PH_DATA;
      default: ph_next = p;
    endcase
  endfunction : ph_next

  logic        fetch;
  logic        raw;
  logic        sb;
  logic        fb;
  logic        wr;
  logic        bound;
  logic [5:0]  idx;
  logic [1:0]  mode;
  logic [1:0]  delta;
  logic [1:0]  q;
  logic [7:0]  nb;
  logic [15:0] len_v;

  always_comb begin
    nxt_s = s_ff;
    fetch = 1'b0;
    raw   = 1'b0;
    sb    = 1'b0;
    fb    = 1'b0;
    bound = 1'b0;
    mode  = MOD_DBPSK;
    delta = 2'h0;
    q     = 2'h0;
    nb    = 8'h00;
    idx   = wb_req_i.adr[7:2];
    len_v = {s_ff.len_hi, s_ff.len_lo};
    wr    = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && s_ff.ack &&
            wb_req_i.sel[0];

    // Power enable pin, two-stage synchroniser
    nxt_s.pe_s1 = transmit_power_enable_i;
    nxt_s.pe_s2 = s_ff.pe_s1;
    nxt_s.pe_d  = s_ff.pe_s2;

    // Bus slave, one wait state, unmapped reads zero
    nxt_s.ack = wb_req_i.cyc && wb_req_i.stb && !s_ff.ack;
    if (nxt_s.ack) begin
      nxt_s.rdat = 8'h00;
      if (idx[5:2] == IDX_SIG0[5:2]) begin
        nxt_s.rdat = s_ff.sig[idx[1:0]];
      end
      case (idx)
        IDX_ROT:   nxt_s.rdat = s_ff.rot;
        IDX_PRE:   nxt_s.rdat = s_ff.pre_len;
        IDX_TAPS:  nxt_s.rdat = s_ff.taps;
        IDX_SFDTO: nxt_s.rdat = s_ff.sfd_to;
        IDX_SETUP: nxt_s.rdat = s_ff.setup;
        IDX_SRV:   nxt_s.rdat = s_ff.srv;
        IDX_LENH:  nxt_s.rdat = s_ff.len_hi;
        IDX_LENL:  nxt_s.rdat = s_ff.len_lo;
        IDX_STAT: begin
          nxt_s.rdat[STAT_BUSY_BIT] = s_ff.active;
          nxt_s.rdat[STAT_UNDR_BIT] = s_ff.underrun;
        end
        default: ;
      endcase
    end
    if (wr) begin
      if (idx[5:2] == IDX_SIG0[5:2]) begin
        nxt_s.sig[idx[1:0]] = wb_req_i.dat[7:0];
      end
      case (idx)
        IDX_ROT:   nxt_s.rot = wb_req_i.dat[7:0];
        IDX_PRE:   nxt_s.pre_len = wb_req_i.dat[7:0];
        IDX_TAPS:  nxt_s.taps = wb_req_i.dat[7:0];
        IDX_SFDTO: nxt_s.sfd_to = wb_req_i.dat[7:0];
        IDX_SETUP: nxt_s.setup = wb_req_i.dat[7:0];
        IDX_SRV:   nxt_s.srv = wb_req_i.dat[7:0];
        IDX_LENH:  nxt_s.len_hi = wb_req_i.dat[7:0];
        IDX_LENL:  nxt_s.len_lo = wb_req_i.dat[7:0];
        IDX_STAT: begin
          if (wb_req_i.dat[STAT_UNDR_BIT]) begin
            nxt_s.underrun = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Bit source, one bit a cycle for the symbol after the current one
    fetch = (s_ff.st != ST_IDLE) && (s_ff.fcnt < s_ff.fk) && !s_ff.last;
    if (fetch) begin
      case (s_ff.ph)
        PH_PRE:  raw = 1'b1; // [RL23]
        PH_SFD:  raw = SFD_VALUE[s_ff.cnt[3:0]];
        PH_SIG:  raw = s_ff.sig[s_ff.setup[1:0]][s_ff.cnt[2:0]]; // [RL4]
        PH_SRV:  raw = s_ff.srv[s_ff.cnt[2:0]]; // [RL5]
        PH_LEN:  raw = len_v[s_ff.cnt[3:0]]; // [RL6]
        PH_CRC:  raw = ~s_ff.crc[4'hF - s_ff.cnt[3:0]]; // [RL25]
        PH_DATA: raw = s_ff.ready && tx_bit_i.valid && tx_bit_i.data; // [RL7]
        default: raw = 1'b0; // [RL7]
      endcase
      // Missing data is sent as zero rather than stalling the chip stream
      if (s_ff.ph == PH_DATA && !tx_bit_i.valid) begin
        nxt_s.underrun = 1'b1;
      end
      if (s_ff.ph == PH_SIG || s_ff.ph == PH_SRV || s_ff.ph == PH_LEN) begin
        fb = raw ^ s_ff.crc[15];
        nxt_s.crc = {s_ff.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000); // [RL25]
      end
      sb = raw ^ (^(s_ff.scr & s_ff.taps[6:0])); // [RL9] [RL10] [RL11]
      nxt_s.scr = {s_ff.scr[5:0], sb}; // [RL11]
      nxt_s.fbits[s_ff.fcnt[2:0]] = sb;
      nxt_s.fcnt = 4'(s_ff.fcnt + 4'h1);
      if (s_ff.ph != PH_DATA && s_ff.ph != PH_DUMMY) begin
        if (s_ff.cnt == ph_last(s_ff.ph, s_ff.pre_len)) begin
          nxt_s.cnt = 8'h00;
          nxt_s.ph  = ph_next(s_ff.ph);
        end else begin
          nxt_s.cnt = 8'(s_ff.cnt + 8'h01);
        end
      end
    end

    // Chip outputs of the symbol in flight
    nxt_s.ci = 1'b0;
    nxt_s.cq = 1'b0;
    if (s_ff.st == ST_RUN && s_ff.out_en) begin
      if (s_ff.cur_mbok) begin
        nxt_s.ci = s_ff.code_i[s_ff.chip[2:0]]; // [RL20]
        nxt_s.cq = s_ff.code_q[s_ff.chip[2:0]]; // [RL20]
      end else begin
        nxt_s.ci = s_ff.cur_i ^ BARKER[s_ff.chip]; // [RL17]
        nxt_s.cq = s_ff.cur_q ^ BARKER[s_ff.chip]; // [RL17]
      end
    end

    case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.pe_s2 && !s_ff.pe_d) begin
          nxt_s.st       = ST_START;
          nxt_s.scr      = SCR_SEED; // [RL12]
          nxt_s.crc      = CRC_PRESET; // [RL25]
          nxt_s.ph       = (s_ff.pre_len == 8'h00) ? PH_SFD : PH_PRE;
          nxt_s.cnt      = 8'h00;
          nxt_s.fcnt     = 4'h0;
          nxt_s.fk       = 4'h1;
          nxt_s.fdata    = 1'b0;
          nxt_s.quad     = 2'h0;
          nxt_s.last     = 1'b0;
          nxt_s.dcnt     = 4'h0;
          nxt_s.out_en   = 1'b0;
          nxt_s.cur_mbok = 1'b0;
        end
      end
      ST_START: begin
        nxt_s.st   = ST_RUN;
        nxt_s.chip = PSK_LAST;
      end
      ST_RUN: begin
        bound = s_ff.chip == (s_ff.cur_mbok ? MBOK_LAST : PSK_LAST);
        if (!bound) begin
          nxt_s.chip = 4'(s_ff.chip + 4'h1);
        end else if (s_ff.last) begin
          nxt_s.st     = ST_IDLE;
          nxt_s.out_en = 1'b0;
        end else begin
          nb   = nxt_s.fbits;
          mode = s_ff.fdata ? s_ff.setup[1:0] : MOD_DBPSK; // [RL2] [RL3]
          nxt_s.chip   = 4'h0;
          nxt_s.out_en = 1'b1;
          case (mode)
            MOD_DBPSK, MOD_DQPSK: begin
              if (mode == MOD_DBPSK) begin
                delta = nb[0] ? 2'h2 : 2'h0; // [RL13]
              end else begin
                case ({nb[0], nb[1]}) // [RL14]
                  2'b00:   delta = 2'h0;
                  2'b01:   delta = 2'h1;
                  2'b11:   delta = 2'h2;
                  default: delta = 2'h3;
                endcase
              end
              if (s_ff.rot[ROT_TX_BIT]) begin
                delta = 2'(2'h0 - delta); // [RL15]
              end
              q = 2'(s_ff.quad + delta);
              nxt_s.quad     = q;
              nxt_s.cur_mbok = 1'b0;
              nxt_s.cur_i    = q[1]; // [RL17]
              nxt_s.cur_q    = q[1] ^ q[0]; // [RL13] [RL17]
              if (!s_ff.fdata) begin
                nxt_s.phref = q[1]; // [RL21]
              end
            end
            MOD_BOK: begin
              nxt_s.cur_mbok = 1'b1;
              nxt_s.code_i   = walsh(nb[3:1]) ^ {8{nb[0] ^ s_ff.phref}}; // [RL18] [RL21]
              nxt_s.code_q   = nxt_s.code_i; // [RL18]
            end
            default: begin
              nxt_s.cur_mbok = 1'b1;
              nxt_s.code_q   = walsh(nb[3:1]) ^ {8{nb[0] ^ s_ff.phref}}; // [RL22] [RL21]
              nxt_s.code_i   = walsh(nb[7:5]) ^ {8{nb[4] ^ s_ff.phref}}; // [RL22] [RL21]
            end
          endcase
          // Decide the source of the next symbol
          if (!s_ff.pe_s2) begin
            if (nxt_s.ph == PH_DATA) begin
              nxt_s.ph = PH_DUMMY; // [RL7] [RL8]
            end else if (nxt_s.ph != PH_DUMMY) begin
              nxt_s.st     = ST_IDLE;
              nxt_s.out_en = 1'b0;
            end
          end
          if (nxt_s.ph == PH_DUMMY) begin
            if (s_ff.dcnt == DUMMY_SYMS) begin
              nxt_s.last = 1'b1;
            end else begin
              nxt_s.dcnt = 4'(s_ff.dcnt + 4'h1);
            end
          end
          nxt_s.fcnt  = 4'h0;
          nxt_s.fdata = (nxt_s.ph == PH_DATA) || (nxt_s.ph == PH_DUMMY);
          nxt_s.fk    = nxt_s.fdata ? bits_per_sym(s_ff.setup[1:0]) : 4'h1;
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase

    nxt_s.ready  = (nxt_s.st != ST_IDLE) && (nxt_s.fcnt < nxt_s.fk) &&
                   !nxt_s.last && (nxt_s.ph == PH_DATA);
    nxt_s.active = nxt_s.st != ST_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff         <= '0;
      s_ff.st      <= ST_IDLE;
      s_ff.ph      <= PH_PRE;
      s_ff.pre_len <= RST_PRE;
      s_ff.taps    <= RST_TAPS;
      s_ff.sfd_to  <= RST_ZERO;
      s_ff.setup   <= RST_ZERO;
      s_ff.srv     <= RST_ZERO;
      s_ff.rot     <= RST_ZERO;
      s_ff.scr     <= SCR_SEED;
      s_ff.crc     <= CRC_PRESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_rsp_o.ack = s_ff.ack;
  assign wb_rsp_o.dat = {24'h00_0000, s_ff.rdat};
  assign tx_bit_ready_o = s_ff.ready;
  assign chip_o.i = s_ff.ci;
  assign chip_o.q = s_ff.cq;
  assign tx_active_o = s_ff.active;

endmodule : dtx_header_modulator

`default_nettype wire

// ---- rtl/dtx_pkg.sv ----
package dtx_pkg;

  // Register word indices, byte address is four times the index
  localparam logic [5:0] IDX_ROT   = 6'h02;
  localparam logic [5:0] IDX_PRE   = 6'h06;
  localparam logic [5:0] IDX_TAPS  = 6'h07;
  localparam logic [5:0] IDX_SFDTO = 6'h0F;
  localparam logic [5:0] IDX_SIG0  = 6'h10;
  localparam logic [5:0] IDX_SETUP = 6'h14;
  localparam logic [5:0] IDX_SRV   = 6'h15;
  localparam logic [5:0] IDX_LENH  = 6'h16;
  localparam logic [5:0] IDX_LENL  = 6'h17;
  localparam logic [5:0] IDX_STAT  = 6'h1F;

  // Field positions
  localparam int ROT_TX_BIT    = 5;
  localparam int ROT_RX_BIT    = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_UNDR_BIT = 1;

  // Reset values
  localparam logic [7:0] RST_PRE  = 8'h80;
  localparam logic [7:0] RST_TAPS = 8'h48;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Coding constants
  localparam logic [6:0]  SCR_SEED   = 7'h6C;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] SFD_VALUE  = 16'hF3A0;
  localparam logic [10:0] BARKER     = 11'h712;
  localparam logic [3:0]  PSK_LAST   = 4'hA;
  localparam logic [3:0]  MBOK_LAST  = 4'h7;
  localparam logic [7:0]  BYTE_LAST  = 8'h07;
  localparam logic [7:0]  WORD_LAST  = 8'h0F;
  localparam logic [3:0]  DUMMY_SYMS = 4'h4;

  // Payload modulation codes
  localparam logic [1:0] MOD_DBPSK = 2'h0;
  localparam logic [1:0] MOD_DQPSK = 2'h1;
  localparam logic [1:0] MOD_BOK   = 2'h2;
  localparam logic [1:0] MOD_QOK   = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN} dtx_st_type;

  typedef enum logic [2:0] {
    PH_PRE, PH_SFD, PH_SIG, PH_SRV, PH_LEN, PH_CRC, PH_DATA, PH_DUMMY
  } dtx_ph_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dtx_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dtx_wb_rsp_type;

  typedef struct packed {
    logic valid;
    logic data;
  } dtx_bit_type;

  typedef struct packed {
    logic i;
    logic q;
  } dtx_chip_type;

endpackage : dtx_pkg

// ---- tb/dtx_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtx_ctrl_model
  import dtx_pkg::*;
(
  // Clock, reset and bench control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [7:0]  payload_i,
  // Link to the transmitter
  input  wire logic        ready_i,
  output var  logic        pe_o,
  output var  dtx_bit_type bit_o
);
  logic [2:0] idx_ff;
  // Released data line toggles, so a stale bit never looks live
  always @(posedge clk_i) begin
    if (rst_i) begin
      pe_o <= 1'b0;
      bit_o <= '0;
      idx_ff <= 3'h0;
    end else if (go_i && !pe_o) begin
      pe_o <= 1'b1;
      idx_ff <= 3'h0;
      bit_o <= '{valid: 1'b1, data: payload_i[0]};
    end else if (pe_o && ready_i && idx_ff == 3'h7) begin
      pe_o <= 1'b0;
      bit_o <= '{valid: 1'b0, data: ~bit_o.data};
    end else if (pe_o && ready_i) begin
      idx_ff <= idx_ff + 3'h1;
      bit_o.data <= payload_i[idx_ff + 3'h1];
    end else if (!bit_o.valid) begin
      bit_o.data <= ~bit_o.data;
    end
  end
endmodule : dtx_ctrl_model
`default_nettype wire

// ---- tb/dtx_header_modulator_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtx_chk
  import dtx_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire dtx_wb_req_type wb_req_i,
  input wire dtx_wb_rsp_type wb_rsp_o,
  input wire logic           transmit_power_enable_i,
  input wire dtx_bit_type    tx_bit_i,
  input wire logic           tx_bit_ready_o,
  input wire dtx_chip_type   chip_o,
  input wire logic           tx_active_o
);
  logic [1:0] md_ff;
  logic       rdy;
  logic       ack;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign rdy = tx_bit_ready_o;
  assign ack = wb_rsp_o.ack;
  // Shadow of setup bits, so fetch rates can be judged per mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      md_ff <= MOD_DBPSK;
    end else if (ack && wb_req_i.we && wb_req_i.sel[0]
                 && wb_req_i.adr[7:2] == IDX_SETUP) begin
      md_ff <= wb_req_i.dat[1:0];
    end
  end
  chk_ack_wait: assert property (wb_req_i.cyc && wb_req_i.stb && !ack
    |=> ack) else $error("ack not after one wait");
  chk_ack_pulse: assert property (ack |=> !ack) else $error("ack held");
  chk_rd_upper: assert property (ack |-> wb_rsp_o.dat[31:8] == 24'h0)
    else $error("read upper bits set");
  chk_iq_equal: assert property (
    tx_active_o && !md_ff[0] |-> chip_o.i == chip_o.q)
    else $error("i and q differ");
  chk_bit_rate: assert property (
    rdy && md_ff == MOD_DBPSK |=> !rdy [*8]) else $error("bit rate");
  chk_dibit_fetch: assert property (
    $rose(rdy) && md_ff == MOD_DQPSK |=> rdy ##1 !rdy [*8])
    else $error("dibit fetch");
  chk_nibble_fetch: assert property (
    $rose(rdy) && md_ff == MOD_BOK |=> rdy [*3] ##1 !rdy [*4])
    else $error("nibble fetch");
  chk_two_nibbles: assert property (
    $rose(rdy) && md_ff == MOD_QOK |=> rdy [*7]) else $error("byte fetch");
  chk_rdy_active: assert property (rdy |-> tx_active_o)
    else $error("fetch while idle");
  chk_idle_chips: assert property (!tx_active_o [*3] |-> chip_o == 2'b00)
    else $error("chips while idle");
  chk_start_pe: assert property ($rose(tx_active_o) |->
    $past(transmit_power_enable_i, 2)) else $error("start without enable");
endmodule : dtx_chk
bind dtx_header_modulator dtx_chk dtx_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .transmit_power_enable_i(transmit_power_enable_i), .tx_bit_i(tx_bit_i),
  .tx_bit_ready_o(tx_bit_ready_o), .chip_o(chip_o),
  .tx_active_o(tx_active_o));
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dtx_pkg::*;
;
  localparam int          P   = 4;
  localparam logic [7:0]  SRV = 8'h5c;
  localparam logic [15:0] LEN = 16'h012a;
  localparam logic [7:0]  WAL [8] = '{8'h03, 8'h0c, 8'h30, 8'h3f,
                                       8'h56, 8'h59, 8'h65, 8'h6a};
  logic           clk_i  = 1'b0;
  logic           rst_i  = 1'b1;
  logic           go     = 1'b0;
  logic           cap_en = 1'b0;
  logic           pe;
  logic           rdy;
  logic           act;
  logic [7:0]     pay    = 8'hb4;
  logic [7:0]     sigv [4] = '{8'h0a, 8'h14, 8'h37, 8'h6e};
  dtx_wb_req_type wb_req = '0;
  dtx_wb_rsp_type wb_rsp;
  dtx_bit_type    txb;
  dtx_chip_type   chip;
  dtx_chip_type   cap [$];
  int             n_fail = 0;
  int             samples_checked = 0;
  int             cyc_n = 0;

  dtx_header_modulator dtx_header_modulator_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .transmit_power_enable_i(pe), .tx_bit_i(txb), .tx_bit_ready_o(rdy),
    .chip_o(chip), .tx_active_o(act));
  dtx_ctrl_model dtx_ctrl_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .payload_i(pay),
    .ready_i(rdy), .pe_o(pe), .bit_o(txb));

  always #4 clk_i = ~clk_i;
  // Capture runs past the end so the trailing symbols are kept
  always @(posedge clk_i) begin
    if (cap_en) cap.push_back(chip);
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wb(input logic we, input logic [5:0] idx,
                    input logic [3:0] sel, input logic [31:0] wd,
                    output logic [31:0] rd);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                sel: sel, dat: wd};
    @(posedge clk_i);
    while (wb_rsp.ack !== 1'b1) @(posedge clk_i);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask : wb

  // Symbol window holds one level spread by the code, same on i and q
  function automatic logic sym_ok(input int o, input int ns);
    logic r;
    r = 1'b1;
    for (int n = 0; n < ns; n++)
      for (int c = 0; c < 11; c++)
        if (o + 11 * n + c >= cap.size() ||
            (cap[o + 11 * n + c].i ^ BARKER[c]) !==
            (cap[o + 11 * n].i ^ BARKER[0]) ||
            cap[o + 11 * n + c].q !== cap[o + 11 * n + c].i) r = 1'b0;
    return r;
  endfunction : sym_ok

  task automatic regs();
    logic [31:0] rd;
    wb(1'b0, IDX_PRE, 4'hf, '0, rd);
    cmp(rd, {24'h0, RST_PRE});
    wb(1'b0, IDX_TAPS, 4'hf, '0, rd);
    cmp(rd, {24'h0, RST_TAPS});
    wb(1'b1, IDX_PRE, 4'he, 32'h0000_0003, rd);
    wb(1'b1, 6'h38, 4'h1, 32'h0000_00ff, rd);
    wb(1'b0, 6'h38, 4'hf, '0, rd);
    cmp(rd, '0);
    wb(1'b1, IDX_PRE, 4'h1, P, rd);
    wb(1'b0, IDX_PRE, 4'hf, '0, rd);
    cmp(rd, P);
    wb(1'b1, IDX_TAPS, 4'h1, '0, rd);
    for (int k = 0; k < 4; k++)
      wb(1'b1, IDX_SIG0 + 6'(k), 4'h1, {24'h0, sigv[k]}, rd);
    wb(1'b1, IDX_SRV, 4'h1, {24'h0, SRV}, rd);
    wb(1'b1, IDX_LENH, 4'h1, {24'h0, LEN[15:8]}, rd);
    wb(1'b1, IDX_LENL, 4'h1, {24'h0, LEN[7:0]}, rd);
    wb(1'b0, IDX_SRV, 4'hf, '0, rd);
    cmp(rd, {24'h0, SRV});
  endtask : regs

  // Taps are zero, so each decoded bit is the unscrambled source bit
  task automatic send(input logic [1:0] md);
    logic [31:0] rd;
    logic [31:0] hdr;
    logic [15:0] crc;
    logic        e [$];
    logic        s;
    logic        sp;
    logic        ph;
    logic [7:0]  gi;
    logic [7:0]  gq;
    logic [7:0]  ei;
    logic [7:0]  eq;
    int          o;
    int          n;
    e = {};
    hdr = {LEN, SRV, sigv[md]};
    crc = CRC_PRESET;
    repeat (P) e.push_back(1'b1);
    for (int k = 0; k < 16; k++) e.push_back(SFD_VALUE[k]);
    for (int k = 0; k < 32; k++) begin
      e.push_back(hdr[k]);
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ hdr[k]) ? CRC_POLY : 16'h0);
    end
    for (int k = 15; k >= 0; k--) e.push_back(~crc[k]);
    if (md == MOD_DBPSK) begin
      for (int k = 0; k < 8; k++) e.push_back(pay[k]);
      repeat (DUMMY_SYMS) e.push_back(1'b0);
    end
    wb(1'b1, IDX_SETUP, 4'h1, {30'h0, md}, rd);
    cap = {};
    cap_en <= 1'b1;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (n < 40 || act !== 1'b0);
    repeat (24) @(posedge clk_i);
    cap_en <= 1'b0;
    o = -1;
    for (int k = 31; k >= 0; k--) if (sym_ok(k, P + 64)) o = k;
    cmp(32'(o >= 0), 32'h0000_0001);
    if (o < 0) o = 0;
    sp = cap[o].i ^ BARKER[0];
    for (n = 1; n < e.size(); n++) begin
      s = cap[o + 11 * n].i ^ BARKER[0];
      cmp({31'h0, s ^ sp}, {31'h0, e[n]});
      sp = s;
    end
    // First keyed symbol: code per nibble, signed by the header phase
    if (md[1]) begin
      ph = cap[o + 11 * (P + 63)].i ^ BARKER[0];
      for (int c = 0; c < 8; c++) begin
        gi[c] = cap[o + 11 * (P + 64) + c].i;
        gq[c] = cap[o + 11 * (P + 64) + c].q;
      end
      eq = WAL[pay[3:1]] ^ {8{pay[0] ^ ph}};
      ei = md[0] ? (WAL[pay[7:5]] ^ {8{pay[4] ^ ph}}) : eq;
      cmp({24'h0, gq}, {24'h0, eq});
      cmp({24'h0, gi}, {24'h0, ei});
    end
  endtask : send

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    regs();
    for (int m = 0; m < 4; m++) send(2'(m));
    test_done();
  end
endmodule : testbench
`default_nettype wire
